// ### sat_interp_model.sv
// fine interpolator stand-in for the acquisition timebase
`timescale 1ns/1ns
`default_nettype none
module sat_interp_model #(
    parameter int DELAY = 5
) (
    // clock
    input wire logic aclk,
    // interpolator handshake
    input wire logic interp_pulse,
    output logic interp_done
);
    int cnt = 0;
    initial interp_done = 1'b0;
    // stretch: done comes DELAY cycles after the pulse ends
    always @(posedge aclk) begin
        if (interp_pulse) begin
            cnt <= DELAY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        interp_done <= (cnt == 1);
    end
endmodule
`default_nettype wire

// ### sat_pkg.sv
// constants, register map and field layout for the acquisition timebase
// Contract
// - ring memory keeps 32768 positions per channel, wraps, never addressed directly
// - ring position is known only by counting memory clocks
// - ring clock runs at half the sample rate, storing on both edges
// - stored samples leave the ring onto the host bus through a buffer
// - sample rates 250 MHz to 2 GHz come from the converter PLL multiplier
// - 100 MHz reference is the base; lower rates come from programmable dividers
// - four trigger sources: channel one, channel two, intermodule bus, external
// - channel comparators pass trigger-true against the chosen level to logic trigger
// - intermodule trigger bus feeds the logic trigger directly
// - pre-trigger samples counted; arm given at the count; triggers only when armed
// - armed trigger hit starts the post-trigger countdown
// - countdown at zero halts sample clocks and tells the host acquisition is done
// - on trigger, pulse to interpolator lasts until the next sample clock
// - interpolator stretches the interval about 500 times before completion
// - counter runs during the stretch, stops at completion, value kept for alignment
// - calibration mux picks probe comp, trigger pulse, self-cal, or reference at 1 ns; the code toggles the reference every 10 ns clock
// - 16-channel DAC sets offsets, trigger levels and static calibration output
// - attenuation 1, 5, 25, 125 with preamp gain; default steps go 1-2-4
`default_nettype none
package sat_pkg;
    localparam int POS_W = 15;
    localparam int RING_DEPTH = 32768;
    localparam logic [14:0] RING_LAST = 15'h7fff;
    localparam int SMP_W = 16;
    localparam int CNT_W = 16;
    localparam int DAC_W = 12;
    localparam int DAC_CH_W = 4;
    localparam int DAC_CH_LSB = 16;
    localparam int FINE_W = 16;
    localparam int CLK_NS = 10;
    localparam int PROBE_HALF_US = 500;
    localparam int PROBE_HALF_CYC = PROBE_HALF_US * 1000 / CLK_NS;
    localparam int STRETCH = 500;
    localparam logic [15:0] FINE_MAX = 16'(STRETCH * 64);
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DIV = 8'h04;
    localparam logic [7:0] OFF_PRE = 8'h08;
    localparam logic [7:0] OFF_POST = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_IST = 8'h14;
    localparam logic [7:0] OFF_IMASK = 8'h18;
    localparam logic [7:0] OFF_FINE = 8'h1c;
    localparam logic [7:0] OFF_DAC = 8'h20;
    localparam logic [7:0] OFF_SENS = 8'h24;
    localparam logic [7:0] OFF_DATA = 8'h28;
    localparam int CTRL_START = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_PLL = 3;
    localparam int CTRL_CAL = 4;
    localparam int CTRL_SELF = 6;
    localparam int CTRL_W = 7;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TRIG = 1;
    localparam int IRQ_ARM = 2;
    localparam int IRQ_W = 3;
    localparam int STAT_POS = 16;
    localparam logic [1:0] SRC_CH1 = 2'h0;
    localparam logic [1:0] SRC_CH2 = 2'h1;
    localparam logic [1:0] SRC_IMB = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    localparam logic [1:0] CAL_PROBE = 2'h0;
    localparam logic [1:0] CAL_TRIG = 2'h1;
    localparam logic [1:0] CAL_SELF = 2'h2;
    localparam logic [1:0] CAL_REF = 2'h3;
    localparam logic [3:0] SENS_STEPS = 4'h3;
    localparam logic [3:0] ATTEN_TOP = 4'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### sat_top.sv
// acquisition timebase, ring memory, trigger, interpolator and AXI4-Lite slave
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module sat_top #(
    parameter int PROBE_HALF = sat_pkg::PROBE_HALF_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // converter side
    input wire logic [15:0] adc_data,
    output logic ring_clk,
    output logic sample_run,
    output logic pll_en,
    // trigger inputs and arm output
    input wire logic trig_ch1,
    input wire logic trig_ch2,
    input wire logic intermodule_trigger_bus,
    input wire logic trig_ext,
    output logic trig_arm,
    // fine interpolator
    output logic interp_pulse,
    input wire logic interp_done,
    // calibration and dac
    output logic calibration_output_mux,
    output logic cal_ref_sel,
    output logic dac_wr,
    output logic [3:0] dac_chan,
    output logic [11:0] dac_val,
    // sensitivity
    output logic [1:0] atten1,
    output logic [1:0] gain1,
    output logic [1:0] atten2,
    output logic [1:0] gain2,
    // interrupt
    output logic irq
);
    typedef enum logic [1:0] {S_IDLE, S_PRE, S_ARMED, S_POST} sat_state_t;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] sens_map(input logic [3:0] step);
        logic [3:0] a;
        logic [3:0] g;
        a = step / sat_pkg::SENS_STEPS;
        g = step % sat_pkg::SENS_STEPS;
        if (a > sat_pkg::ATTEN_TOP) begin
            a = sat_pkg::ATTEN_TOP;
        end
        return {a[1:0], g[1:0]};
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0] ring_mem [sat_pkg::RING_DEPTH];
    sat_state_t state_reg;
    logic aw_full_reg, w_full_reg, rstage_reg;
    logic [7:0] awaddr_reg, araddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [31:0] ctrl_reg, div_reg, pre_reg, post_reg, sens_reg;
    logic [sat_pkg::IRQ_W-1:0] ist_reg, imask_reg;
    logic [1:0] src_cfg_reg;
    logic pll_cfg_reg;
    logic [15:0] div_cfg_reg, pre_cfg_reg, post_cfg_reg, div_cnt_reg, pre_cnt_reg, post_cnt_reg;
    logic [14:0] pos_reg, rd_pos_reg;
    logic [15:0] mem_q_reg;
    logic ip_reg, fine_run_reg;
    logic [15:0] fine_cnt_reg, fine_q_reg;
    logic [31:0] pc_cnt_reg;
    logic pc_sq_reg;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire do_wr = aw_full_reg && w_full_reg && !bvalid;
    wire wr_ctrl = do_wr && awaddr_reg == sat_pkg::OFF_CTRL;
    wire wr_div = do_wr && awaddr_reg == sat_pkg::OFF_DIV;
    wire wr_pre = do_wr && awaddr_reg == sat_pkg::OFF_PRE;
    wire wr_post = do_wr && awaddr_reg == sat_pkg::OFF_POST;
    wire wr_ist = do_wr && awaddr_reg == sat_pkg::OFF_IST;
    wire wr_imask = do_wr && awaddr_reg == sat_pkg::OFF_IMASK;
    wire wr_dac = do_wr && awaddr_reg == sat_pkg::OFF_DAC;
    wire wr_sens = do_wr && awaddr_reg == sat_pkg::OFF_SENS;
    wire wr_hit = wr_ctrl | wr_div | wr_pre | wr_post | wr_ist | wr_imask | wr_dac | wr_sens;
    wire ar_take = arvalid && arready;
    wire rd_data = rstage_reg && araddr_reg == sat_pkg::OFF_DATA;
    wire [31:0] wval = wmerge(32'h0000_0000, wdata_reg, wstrb_reg);
    // start must latch the word being written, not the previous one
    wire [31:0] ctrl_new = wmerge(ctrl_reg, wdata_reg, wstrb_reg);
    wire start = wr_ctrl && wval[sat_pkg::CTRL_START] && state_reg == S_IDLE;
    wire run = state_reg != S_IDLE;
    // sample clock: reference divided, or every reference cycle under the pll
    wire tick = run && (pll_cfg_reg || div_cnt_reg == div_cfg_reg);
    wire ring_we = tick;
    wire [14:0] pos_inc = 15'(pos_reg + 15'h0001);
    wire sel_trig = src_cfg_reg == sat_pkg::SRC_CH1 ? trig_ch1 :
                    src_cfg_reg == sat_pkg::SRC_CH2 ? trig_ch2 :
                    src_cfg_reg == sat_pkg::SRC_IMB ? intermodule_trigger_bus :
                    trig_ext;
    wire trig_hit = state_reg == S_ARMED && sel_trig;
    wire arm_now = state_reg == S_PRE && tick && pre_cnt_reg == pre_cfg_reg;
    wire done_now = state_reg == S_POST && tick && post_cnt_reg == 16'h0000;
    wire fine_stop = fine_run_reg && (interp_done || fine_cnt_reg == sat_pkg::FINE_MAX);
    wire [sat_pkg::IRQ_W-1:0] ev = {arm_now, trig_hit, done_now};
    wire [sat_pkg::IRQ_W-1:0] ist_clr = wr_ist ? wval[sat_pkg::IRQ_W-1:0] : 3'h0;
    wire [1:0] cal_mode = ctrl_reg[sat_pkg::CTRL_CAL +: 2];
    wire [3:0] s1 = sens_map(sens_reg[3:0]);
    wire [3:0] s2 = sens_map(sens_reg[7:4]);
    wire [31:0] stat_w = {1'b0, pos_reg, 13'h0000, fine_run_reg, state_reg == S_ARMED, run};
    wire [31:0] rd_mux = araddr_reg == sat_pkg::OFF_CTRL ? ctrl_reg :
                         araddr_reg == sat_pkg::OFF_DIV ? div_reg :
                         araddr_reg == sat_pkg::OFF_PRE ? pre_reg :
                         araddr_reg == sat_pkg::OFF_POST ? post_reg :
                         araddr_reg == sat_pkg::OFF_STAT ? stat_w :
                         araddr_reg == sat_pkg::OFF_IST ? {29'h0000_0000, ist_reg} :
                         araddr_reg == sat_pkg::OFF_IMASK ? {29'h0000_0000, imask_reg} :
                         araddr_reg == sat_pkg::OFF_FINE ? {16'h0000, fine_q_reg} :
                         araddr_reg == sat_pkg::OFF_SENS ? sens_reg :
                         {16'h0000, mem_q_reg};
    wire rd_hit = araddr_reg <= sat_pkg::OFF_DATA && araddr_reg[1:0] == 2'h0 &&
                  araddr_reg != sat_pkg::OFF_DAC;

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid <= 1'b0;
            bresp <= sat_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
                wready <= 1'b0;
            end
            if (do_wr) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? sat_pkg::RESP_OKAY : sat_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rstage_reg <= 1'b0;
            araddr_reg <= 8'h00;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= sat_pkg::RESP_OKAY;
        end else begin
            rstage_reg <= ar_take;
            if (ar_take) begin
                arready <= 1'b0;
                araddr_reg <= araddr;
            end
            if (rstage_reg) begin
                rvalid <= 1'b1;
                rdata <= rd_hit ? rd_mux : 32'h0000_0000;
                rresp <= rd_hit ? sat_pkg::RESP_OKAY : sat_pkg::RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // host registers, shadow load at start
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= 32'h0000_0000;
            div_reg <= 32'h0000_0000;
            pre_reg <= 32'h0000_0000;
            post_reg <= 32'h0000_0000;
            sens_reg <= 32'h0000_0000;
            imask_reg <= 3'h0;
            ist_reg <= 3'h0;
            src_cfg_reg <= sat_pkg::SRC_CH1;
            pll_cfg_reg <= 1'b0;
            div_cfg_reg <= 16'h0000;
            pre_cfg_reg <= 16'h0000;
            post_cfg_reg <= 16'h0000;
        end else begin
            if (wr_ctrl) ctrl_reg <= ctrl_new & 32'h0000_007e;
            if (wr_div) div_reg <= wmerge(div_reg, wdata_reg, wstrb_reg) & 32'h0000_ffff;
            if (wr_pre) pre_reg <= wmerge(pre_reg, wdata_reg, wstrb_reg) & 32'h0000_ffff;
            if (wr_post) post_reg <= wmerge(post_reg, wdata_reg, wstrb_reg) & 32'h0000_ffff;
            if (wr_sens) sens_reg <= wmerge(sens_reg, wdata_reg, wstrb_reg) & 32'h0000_00ff;
            if (wr_imask) imask_reg <= wval[sat_pkg::IRQ_W-1:0];
            ist_reg <= (ist_reg & ~ist_clr) | ev;
            if (start) begin
                src_cfg_reg <= ctrl_new[sat_pkg::CTRL_SRC +: 2];
                pll_cfg_reg <= ctrl_new[sat_pkg::CTRL_PLL];
                div_cfg_reg <= div_reg[15:0];
                pre_cfg_reg <= pre_reg[15:0];
                post_cfg_reg <= post_reg[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // acquisition sequence
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= S_IDLE;
            div_cnt_reg <= 16'h0000;
            pre_cnt_reg <= 16'h0000;
            post_cnt_reg <= 16'h0000;
        end else begin
            div_cnt_reg <= (tick || !run) ? 16'h0000 : 16'(div_cnt_reg + 16'h0001);
            unique case (state_reg)
                S_IDLE: begin
                    pre_cnt_reg <= 16'h0000;
                    if (start) state_reg <= S_PRE;
                end
                S_PRE: begin
                    if (arm_now) state_reg <= S_ARMED;
                    else if (tick) pre_cnt_reg <= 16'(pre_cnt_reg + 16'h0001);
                end
                S_ARMED: begin
                    if (trig_hit) begin
                        state_reg <= S_POST;
                        post_cnt_reg <= post_cfg_reg;
                    end
                end
                S_POST: begin
                    if (done_now) state_reg <= S_IDLE;
                    else if (tick) post_cnt_reg <= 16'(post_cnt_reg - 16'h0001);
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // ring memory: position is the count of memory clocks
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (ring_we) ring_mem[pos_reg] <= adc_data;
        mem_q_reg <= ring_mem[rd_pos_reg];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_reg <= 15'h0000;
            rd_pos_reg <= 15'h0000;
            ring_clk <= 1'b0;
        end else begin
            if (ring_we) begin
                pos_reg <= pos_inc;
                ring_clk <= ~ring_clk;
            end
            if (done_now) rd_pos_reg <= pos_inc;
            else if (rd_data) rd_pos_reg <= 15'(rd_pos_reg + 15'h0001);
        end
    end

    // ----------------------------------------------------------------
    // fine interpolator timing
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ip_reg <= 1'b0;
            fine_run_reg <= 1'b0;
            fine_cnt_reg <= 16'h0000;
            fine_q_reg <= 16'h0000;
        end else begin
            if (trig_hit) ip_reg <= 1'b1;
            else if (ip_reg && tick) ip_reg <= 1'b0;
            if (ip_reg && tick) begin
                fine_run_reg <= 1'b1;
                fine_cnt_reg <= 16'h0000;
            end else if (fine_stop) begin
                fine_run_reg <= 1'b0;
                fine_q_reg <= fine_cnt_reg;
            end else if (fine_run_reg) begin
                fine_cnt_reg <= 16'(fine_cnt_reg + 16'h0001);
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs: clocks, calibration, dac, sensitivity, interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_run <= 1'b0;
            pll_en <= 1'b0;
            trig_arm <= 1'b0;
            interp_pulse <= 1'b0;
            pc_cnt_reg <= 32'h0000_0000;
            pc_sq_reg <= 1'b0;
            calibration_output_mux <= 1'b0;
            cal_ref_sel <= 1'b0;
            dac_wr <= 1'b0;
            dac_chan <= 4'h0;
            dac_val <= 12'h000;
            {atten1, gain1, atten2, gain2} <= 8'h00;
            irq <= 1'b0;
        end else begin
            sample_run <= run && !done_now;
            pll_en <= run && pll_cfg_reg;
            trig_arm <= state_reg == S_ARMED || arm_now;
            interp_pulse <= trig_hit || (ip_reg && !tick);
            if (pc_cnt_reg == 32'(PROBE_HALF - 1)) begin
                pc_cnt_reg <= 32'h0000_0000;
                pc_sq_reg <= ~pc_sq_reg;
            end else begin
                pc_cnt_reg <= 32'(pc_cnt_reg + 32'h0000_0001);
            end
            unique case (cal_mode)
                sat_pkg::CAL_PROBE: calibration_output_mux <= pc_sq_reg;
                sat_pkg::CAL_TRIG: calibration_output_mux <= ip_reg;
                sat_pkg::CAL_SELF: calibration_output_mux <= ctrl_reg[sat_pkg::CTRL_SELF];
                sat_pkg::CAL_REF: calibration_output_mux <= ~calibration_output_mux;
            endcase
            cal_ref_sel <= cal_mode == sat_pkg::CAL_REF;
            dac_wr <= wr_dac;
            if (wr_dac) begin
                dac_chan <= wdata_reg[sat_pkg::DAC_CH_LSB +: sat_pkg::DAC_CH_W];
                dac_val <= wdata_reg[sat_pkg::DAC_W-1:0];
            end
            {atten1, gain1, atten2, gain2} <= {s1, s2};
            irq <= |(ist_reg & imask_reg);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RING_WRAP: assert property (
        ring_we && pos_reg == sat_pkg::RING_LAST |=> pos_reg == 15'h0000)
        else $error("ring position did not wrap");
    AST_POS_COUNT: assert property (ring_we |=> pos_reg == 15'($past(pos_reg) + 15'h0001))
        else $error("ring position not advanced by one clock");
    AST_RING_CLK: assert property (ring_we |=> ring_clk != $past(ring_clk))
        else $error("ring clock edge missing for sample");
    AST_DATA_READ: assert property (
        ar_take && araddr == sat_pkg::OFF_DATA && state_reg == S_IDLE |->
        ##2 rvalid && rd_pos_reg == 15'($past(rd_pos_reg, 2) + 15'h0001))
        else $error("sample read did not advance");
    AST_ARM: assert property (arm_now |=> state_reg == S_ARMED ##1 trig_arm)
        else $error("arm not raised after pre-trigger count");
    AST_NO_EARLY: assert property (state_reg == S_PRE |=> state_reg != S_POST)
        else $error("trigger accepted while not armed");
    AST_POST_LOAD: assert property (
        trig_hit |=> state_reg == S_POST && post_cnt_reg == $past(post_cfg_reg))
        else $error("post countdown not started");
    AST_DONE: assert property (
        done_now |=> state_reg == S_IDLE && ist_reg[sat_pkg::IRQ_DONE] && !sample_run)
        else $error("acquisition end not signalled");
    AST_INTERP: assert property (trig_hit |=> interp_pulse && ip_reg)
        else $error("interpolator pulse missing after trigger");
    AST_FINE_STOP: assert property (
        fine_run_reg && interp_done && !(ip_reg && tick) |=>
        !fine_run_reg && fine_q_reg == $past(fine_cnt_reg))
        else $error("fine count not captured");

    COV_ACQ: cover property (done_now);
    COV_WRAP: cover property (ring_we && pos_reg == sat_pkg::RING_LAST);
    COV_FINE: cover property (fine_run_reg && interp_done);
endmodule
`default_nettype wire

// ### tb_scope_acquisition_timebase.sv
// testbench for the acquisition timebase
`timescale 1ns/1ns
`default_nettype none
module tb_scope_acquisition_timebase;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ring_clk, sample_run, pll_en, trig_arm;
    logic trig_ch1, trig_ch2, intermodule_trigger_bus, trig_ext, interp_pulse;
    logic interp_done, calibration_output_mux, cal_ref_sel, dac_wr, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, dac_chan;
    logic [1:0] bresp, rresp, atten1, gain1, atten2, gain2;
    logic [15:0] adc_data;
    logic [11:0] dac_val;
    int mismatches = 0;
    int total_checks = 0;
    sat_top #(.PROBE_HALF(4)) u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .rvalid, .rready, .rdata, .rresp, .adc_data, .ring_clk, .sample_run,
        .pll_en, .trig_ch1, .trig_ch2, .intermodule_trigger_bus, .trig_ext, .trig_arm,
        .interp_pulse, .interp_done, .calibration_output_mux, .cal_ref_sel, .dac_wr,
        .dac_chan, .dac_val, .atten1, .gain1, .atten2, .gain2, .irq);
    sat_interp_model u_interp (.aclk, .interp_pulse, .interp_done);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk(bresp, e);
    endtask
    task automatic rdr(input logic [7:0] a, input logic [1:0] e);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        rd = rdata;
        chk(rresp, e);
    endtask
    initial begin
        int n;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {trig_ch1, trig_ch2, intermodule_trigger_bus, trig_ext} = 4'h0;
        {awaddr, araddr, wdata} = 48'h0000_0000_0000;
        wstrb = 4'hf;
        adc_data = 16'h1234;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(8'h40, sat_pkg::RESP_SLVERR);
        chk(rd, 32'h0000_0000);
        rdr(sat_pkg::OFF_DAC, sat_pkg::RESP_SLVERR);
        $display("test map done");
        wr(sat_pkg::OFF_DAC, 32'h0005_0abc, sat_pkg::RESP_OKAY);
        chk({dac_wr, dac_chan, dac_val}, 32'h0001_5abc);
        wr(sat_pkg::OFF_SENS, 32'h0000_0075, sat_pkg::RESP_OKAY);
        @(posedge aclk);
        chk({atten1, gain1, atten2, gain2}, 32'h0000_0069);
        $display("test dac and sensitivity done");
        wr(sat_pkg::OFF_DIV, 32'h0000_0000, sat_pkg::RESP_OKAY);
        wr(sat_pkg::OFF_PRE, 32'h0000_0003, sat_pkg::RESP_OKAY);
        wr(sat_pkg::OFF_POST, 32'h0000_0002, sat_pkg::RESP_OKAY);
        wr(sat_pkg::OFF_IMASK, 32'h0000_0000, sat_pkg::RESP_OKAY);
        wr(sat_pkg::OFF_CTRL, 32'h0000_0007, sat_pkg::RESP_OKAY);
        for (n = 0; n < 100 && trig_arm !== 1'b1; n++) @(posedge aclk);
        chk(sample_run, 32'h0000_0001);
        rdr(sat_pkg::OFF_IST, sat_pkg::RESP_OKAY);
        chk(rd[2:0], 32'h0000_0004);
        trig_ext <= 1'b1;
        for (n = 0; n < 300 && sample_run === 1'b1; n++) @(posedge aclk);
        trig_ext <= 1'b0;
        chk(irq, 32'h0000_0000);
        rdr(sat_pkg::OFF_IST, sat_pkg::RESP_OKAY);
        chk(rd[2:0], 32'h0000_0007);
        rdr(sat_pkg::OFF_FINE, sat_pkg::RESP_OKAY);
        chk(rd[15:0] != 16'h0000, 32'h0000_0001);
        wr(sat_pkg::OFF_IMASK, 32'h0000_0001, sat_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(irq, 32'h0000_0001);
        wr(sat_pkg::OFF_IST, 32'h0000_0001, sat_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(irq, 32'h0000_0000);
        $display("test acquisition done");
        wr(sat_pkg::OFF_IST, 32'h0000_0007, sat_pkg::RESP_OKAY);
        rdr(sat_pkg::OFF_STAT, sat_pkg::RESP_OKAY);
        chk(ring_clk, rd[sat_pkg::STAT_POS]);
        n = rd[30:16];
        intermodule_trigger_bus <= 1'b1;
        // bus source, pll, reference mode; trigger already high before arming
        wr(sat_pkg::OFF_CTRL, 32'h0000_003d, sat_pkg::RESP_OKAY);
        @(posedge aclk);
        chk({pll_en, cal_ref_sel, sample_run}, 32'h0000_0007);
        rd[0] = calibration_output_mux;
        @(posedge aclk);
        chk(calibration_output_mux ^ rd[0], 32'h0000_0001);
        for (int i = 0; i < 300 && sample_run === 1'b1; i++) @(posedge aclk);
        intermodule_trigger_bus <= 1'b0;
        rdr(sat_pkg::OFF_STAT, sat_pkg::RESP_OKAY);
        // pre+1 ticks, one armed tick, post+1 ticks
        chk(rd[30:16], 32'(n + 8));
        chk(irq, 32'h0000_0001);
        rdr(sat_pkg::OFF_DATA, sat_pkg::RESP_OKAY);
        $display("test bus trigger and pll done");
        end_of_test();
    end
    initial begin
        #500000;
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
